// ===== logic/wosc_top.sv
/*
 * Write-once configuration bank: APB registers, memory decoder,
 * watchdog prescaler and stop wake-up delay.
 * Assumes an APB master on pclk and synchronous strap and request inputs.
 */
// The APB interface to the registers was left to the implementer.
//
// Notes on behaviour
// R01: Normal mode: protected bits take one write, only within 64 cycles of reset.
// R02: Special mode lets protected bits be written at any time.
// R03: Software should program protected registers before clearing special mode.
// R04: Normal mode: startup register takes one write; watchdog enabled out of reset.
// R05: Startup register bits 7..3 and 0 read zero.
// R06: Watchdog disable resets to zero; one disables the watchdog.
// R07: ROM enable resets to one; once in normal, any time in special.
// R08: ROM sits at page 7 in expanded mode, page F otherwise.
// R09: Mapping register takes one write within 64 cycles, then read-only.
// R10: RAM page bits give top digit; RAM decodes n040..n0FF, default page 0.
// R11: Register page bits give top digit of 64-byte window n000..n03F.
// R12: Registers and RAM take precedence over ROM on overlap.
// R13: Edge, delay and rate option bits take one write after reset.
// R14: Special mode: option protected bits writable at any time.
// R15: Option bits 7, 6 and 2 read zero.
// R16: Edge select zero is level, one is edge only; resets zero.
// R17: Delay bit set: wake from stop waits about 4000 cycles.
// R18: Delay bit clear: processing resumes about four cycles after stop.
// R19: Watchdog clock is pclk over 2^15, scaled by rate bits.
// R20: Clock monitor enable bit switches the monitor on or off.
// R21: Special flag set when mode B low at reset; software may only clear.
// R22: Refused protected writes are silently ignored.
// R23: Clock monitor enable stays writable at any time.
`timescale 1ns/1ps
`default_nettype none
`include "wosc_params.svh"

module wosc_top
    import wosc_pkg::*;
#(
    parameter int WDOG_DIV_LOG2 = `WOSC_WDOG_DIV_LOG2
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mode_a_pin,
    input  wire logic        mode_b_pin,
    input  wire logic [15:0] cpu_addr,
    output wosc_hit_t        cpu_hit,
    input  wire logic        stop_exit_req,
    output logic             cpu_resume,
    output logic             watchdog_disable,
    output logic             rom_map_enable,
    output wosc_opt_t        options,
    output logic             special_mode_flag,
    output logic             watchdog_tick
);

    localparam int WCNT_W = WDOG_DIV_LOG2 + 6;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // A protected write lands in special mode, or once inside the window.
    function automatic logic write_allowed(input logic special,
                                           input logic window_open,
                                           input logic done);
        write_allowed = special | (window_open & ~done); // R01 R02
    endfunction

    // True when the top hex digit of an address matches a page select.
    function automatic logic page_match(input logic [15:0] addr,
                                        input logic [3:0]  page);
        page_match = (addr[15:12] == page);
    endfunction

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    logic              strap_done_reg, strap_done_next, special_reg, special_next;
    logic              mode_a_reg, mode_a_next, startup_done_reg, startup_done_next;
    logic              mapping_done_reg, mapping_done_next, options_done_reg, options_done_next;
    logic              wdog_dis_reg, wdog_dis_next, rom_en_reg, rom_en_next;
    logic              pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic              resume_reg, resume_next, wtick_reg, wtick_next;
    logic [6:0]        window_cnt_reg, window_cnt_next;
    logic [3:0]        ram_page_reg, ram_page_next, reg_page_reg, reg_page_next;
    logic [11:0]       wake_cnt_reg, wake_cnt_next;
    logic [31:0]       prdata_reg, prdata_next;
    logic [WCNT_W-1:0] wcnt_reg, wcnt_next;
    wosc_opt_t         opt_reg, opt_next;
    wosc_hit_t         hit_reg, hit_next;
    wosc_wake_t        wake_reg, wake_next;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic [7:0] reg_index, wbyte;
    logic       byte_aligned, mapped, wr_commit, window_open;
    logic       hit_status, hit_options, hit_mode, hit_mapping, hit_startup;

    // Registers are one word apart; misaligned accesses index 0xff, which is unused.
    assign reg_index    = byte_aligned ? paddr[9:2] : 8'hff;
    assign byte_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign wbyte        = pwdata[7:0];
    assign window_open  = (window_cnt_reg < `WOSC_WINDOW_CYC);

    // Address decode by if and else-if so each index maps to one register.
    always_comb
    begin
        hit_status  = 1'b0;
        hit_options = 1'b0;
        hit_mode    = 1'b0;
        hit_mapping = 1'b0;
        hit_startup = 1'b0;
        if (reg_index == `WOSC_IDX_STATUS)
        begin
            hit_status = 1'b1;
        end
        else if (reg_index == `WOSC_IDX_OPTIONS)
        begin
            hit_options = 1'b1;
        end
        else if (reg_index == `WOSC_IDX_MODE)
        begin
            hit_mode = 1'b1;
        end
        else if (reg_index == `WOSC_IDX_MAPPING)
        begin
            hit_mapping = 1'b1;
        end
        else if (reg_index == `WOSC_IDX_STARTUP)
        begin
            hit_startup = 1'b1;
        end
    end

    assign mapped = hit_status | hit_options | hit_mode | hit_mapping | hit_startup;

    // A write takes effect only at the edge that closes the access phase,
    // and only when the byte lane holding the register is strobed.
    assign wr_commit = psel & penable & pready_reg & pwrite & mapped & pstrb[0];

    // ------------------------------------------------------------------------
    // APB response: no wait states, data captured during the setup cycle
    // ------------------------------------------------------------------------
    always_comb
    begin
        pready_next  = psel & ~penable;
        pslverr_next = psel & ~penable & ~mapped;
        prdata_next  = prdata_reg;
        if (psel && !penable)
        begin
            prdata_next = 32'h0000_0000;
            if (hit_startup)
            begin
                // Unimplemented bits stay zero.
                prdata_next[`WOSC_CFG_WDOG_DIS] = wdog_dis_reg; // R05
                prdata_next[`WOSC_CFG_ROM_EN]   = rom_en_reg;
            end
            else if (hit_mapping)
            begin
                prdata_next[7:0] = {ram_page_reg, reg_page_reg};
            end
            else if (hit_options)
            begin
                prdata_next[`WOSC_OPT_EDGE]  = opt_reg.interrupt_edge_select; // R15
                prdata_next[`WOSC_OPT_DELAY] = opt_reg.stop_wake_delay_enable;
                prdata_next[`WOSC_OPT_CME]   = opt_reg.clock_monitor_enable;
                prdata_next[1:0]             = opt_reg.watchdog_rate_select;
            end
            else if (hit_mode)
            begin
                prdata_next[`WOSC_MODE_SPECIAL] = special_reg;
                prdata_next[`WOSC_MODE_MODE_A]  = mode_a_reg;
            end
            else if (hit_status)
            begin
                prdata_next[3:0] = {options_done_reg, mapping_done_reg,
                                    startup_done_reg, window_open};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Strap capture and window counter
    // ------------------------------------------------------------------------

    // Straps land at the first edge after reset; the window counts each cycle until it holds at 64.
    always_comb
    begin
        strap_done_next = 1'b1;
        special_next    = special_reg;
        mode_a_next     = mode_a_reg;
        window_cnt_next = window_cnt_reg;
        if (!strap_done_reg)
        begin
            special_next = ~mode_b_pin; // R21
            mode_a_next  = mode_a_pin;
        end
        else if (wr_commit && hit_mode && !wbyte[`WOSC_MODE_SPECIAL])
        begin
            special_next = 1'b0; // R21
        end
        if (window_open)
        begin
            window_cnt_next = window_cnt_reg + 7'd1; // R01
        end
    end

    // ------------------------------------------------------------------------
    // Protected configuration registers
    // ------------------------------------------------------------------------

    // Refused writes fall through with every value held except the monitor enable.
    always_comb
    begin
        startup_done_next = startup_done_reg;
        mapping_done_next = mapping_done_reg;
        options_done_next = options_done_reg;
        wdog_dis_next     = wdog_dis_reg;
        rom_en_next       = rom_en_reg;
        ram_page_next     = ram_page_reg;
        reg_page_next     = reg_page_reg;
        opt_next          = opt_reg;
        if (wr_commit && hit_startup &&
            write_allowed(special_reg, window_open, startup_done_reg)) // R04 R22
        begin
            wdog_dis_next     = wbyte[`WOSC_CFG_WDOG_DIS]; // R06
            rom_en_next       = wbyte[`WOSC_CFG_ROM_EN]; // R07
            startup_done_next = 1'b1;
        end
        if (wr_commit && hit_mapping &&
            write_allowed(special_reg, window_open, mapping_done_reg)) // R09 R22
        begin
            ram_page_next     = wbyte[7:4];
            reg_page_next     = wbyte[3:0];
            mapping_done_next = 1'b1;
        end
        if (wr_commit && hit_options)
        begin
            // The monitor enable is not time protected.
            opt_next.clock_monitor_enable = wbyte[`WOSC_OPT_CME]; // R20 R23
            if (write_allowed(special_reg, window_open, options_done_reg)) // R13 R14 R22
            begin
                opt_next.interrupt_edge_select  = wbyte[`WOSC_OPT_EDGE]; // R16
                opt_next.stop_wake_delay_enable = wbyte[`WOSC_OPT_DELAY];
                opt_next.watchdog_rate_select   = wbyte[1:0];
                options_done_next               = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Memory window decoder
    // ------------------------------------------------------------------------

    // Result is one cycle behind the address; registers beat RAM beat ROM.
    always_comb
    begin
        logic reg_win;
        logic ram_win;
        logic rom_win;
        logic [3:0] rom_page;
        reg_win  = page_match(cpu_addr, reg_page_reg) && (cpu_addr[11:6] == 6'h00); // R11
        ram_win  = page_match(cpu_addr, ram_page_reg) && (cpu_addr[11:8] == 4'h0) &&
                   (cpu_addr[7:0] >= `WOSC_RAM_LOW_LIMIT); // R10
        rom_page = (!special_reg && mode_a_reg) ? `WOSC_ROM_PAGE_EXP
                                                : `WOSC_ROM_PAGE_STD; // R08
        rom_win  = rom_en_reg && page_match(cpu_addr, rom_page);
        hit_next.reg_hit = reg_win; // R12
        hit_next.ram_hit = ram_win & ~reg_win;
        hit_next.rom_hit = rom_win & ~reg_win & ~ram_win;
    end

    // ------------------------------------------------------------------------
    // Stop wake-up sequencer
    // ------------------------------------------------------------------------

    // The delay choice is sampled when stop ends; a new request mid-wait
    // is ignored so the oscillator always gets its full settling time.
    always_comb
    begin
        wake_next     = wake_reg;
        wake_cnt_next = wake_cnt_reg;
        resume_next   = 1'b0;
        case (wake_reg)
            WOSC_RUN:
            begin
                if (stop_exit_req)
                begin
                    wake_next     = WOSC_WAKE;
                    wake_cnt_next = opt_reg.stop_wake_delay_enable ?
                                    `WOSC_STOP_DLY_CYC - 12'd1 :
                                    `WOSC_STOP_FAST_CYC - 12'd1; // R17 R18
                end
            end
            WOSC_WAKE:
            begin
                if (wake_cnt_reg == 12'd0)
                begin
                    wake_next   = WOSC_RUN;
                    resume_next = 1'b1;
                end
                else
                begin
                    wake_cnt_next = wake_cnt_reg - 12'd1;
                end
            end
            default:
            begin
                wake_next = WOSC_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Watchdog prescaler
    // ------------------------------------------------------------------------

    // One tick per 2^(15+2*rate) cycles: factors 1, 4, 16 and 64.
    always_comb
    begin
        int lim;
        logic [WCNT_W-1:0] mask;
        lim  = WDOG_DIV_LOG2 + 2 * int'(opt_reg.watchdog_rate_select); // R19
        mask = '0;
        for (int i = 0; i < WCNT_W; i++)
        begin
            mask[i] = (i < lim);
        end
        wtick_next = ((wcnt_reg & mask) == mask);
        wcnt_next  = wcnt_reg + {{(WCNT_W-1){1'b0}}, 1'b1};
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_done_reg   <= 1'b0;
            special_reg      <= 1'b0;
            mode_a_reg       <= 1'b0;
            window_cnt_reg   <= 7'd0;
            startup_done_reg <= 1'b0;
            mapping_done_reg <= 1'b0;
            options_done_reg <= 1'b0;
            wdog_dis_reg     <= 1'(`WOSC_RST_STARTUP >> `WOSC_CFG_WDOG_DIS); // R06
            rom_en_reg       <= 1'b1; // R07
            ram_page_reg     <= 4'(`WOSC_RST_MAPPING >> 4); // R10
            reg_page_reg     <= 4'(`WOSC_RST_MAPPING); // R11
            opt_reg          <= 5'(`WOSC_RST_OPTIONS >> 1) | 5'(`WOSC_RST_OPTIONS & 8'h03);
            prdata_reg       <= 32'h0000_0000;
            pready_reg       <= 1'b0;
            pslverr_reg      <= 1'b0;
            hit_reg          <= '0;
            wake_reg         <= WOSC_RUN;
            wake_cnt_reg     <= 12'd0;
            resume_reg       <= 1'b0;
            wcnt_reg         <= '0;
            wtick_reg        <= 1'b0;
        end
        else
        begin
            strap_done_reg   <= strap_done_next;
            special_reg      <= special_next;
            mode_a_reg       <= mode_a_next;
            window_cnt_reg   <= window_cnt_next;
            startup_done_reg <= startup_done_next;
            mapping_done_reg <= mapping_done_next;
            options_done_reg <= options_done_next;
            wdog_dis_reg     <= wdog_dis_next;
            rom_en_reg       <= rom_en_next;
            ram_page_reg     <= ram_page_next;
            reg_page_reg     <= reg_page_next;
            opt_reg          <= opt_next;
            prdata_reg       <= prdata_next;
            pready_reg       <= pready_next;
            pslverr_reg      <= pslverr_next;
            hit_reg          <= hit_next;
            wake_reg         <= wake_next;
            wake_cnt_reg     <= wake_cnt_next;
            resume_reg       <= resume_next;
            wcnt_reg         <= wcnt_next;
            wtick_reg        <= wtick_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign cpu_hit           = hit_reg;
    assign cpu_resume        = resume_reg;
    assign watchdog_disable  = wdog_dis_reg;
    assign rom_map_enable    = rom_en_reg;
    assign options           = opt_reg;
    assign special_mode_flag = special_reg;
    assign watchdog_tick     = wtick_reg;

endmodule

`default_nettype wire

// ===== logic/wosc_params.svh
/*
 * Register indices, field positions, reset values and timing counts.
 * Assumes inclusion by bare name.
 */
`ifndef WOSC_PARAMS_SVH
`define WOSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define WOSC_IDX_STATUS      8'h30
`define WOSC_IDX_OPTIONS     8'h39
`define WOSC_IDX_MODE        8'h3c
`define WOSC_IDX_MAPPING     8'h3d
`define WOSC_IDX_STARTUP     8'h3f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WOSC_CFG_WDOG_DIS    2
`define WOSC_CFG_ROM_EN      1
`define WOSC_OPT_EDGE        5
`define WOSC_OPT_DELAY       4
`define WOSC_OPT_CME         3
`define WOSC_OPT_RATE_LSB    0
`define WOSC_MODE_SPECIAL    6
`define WOSC_MODE_MODE_A     5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WOSC_RST_MAPPING     8'h00
`define WOSC_RST_OPTIONS     8'h10
`define WOSC_RST_STARTUP     8'h02

// ----------------------------------------------------------------------------
// Timing counts in E-clock (pclk) cycles, ROM pages and RAM low limit
// ----------------------------------------------------------------------------
`define WOSC_WINDOW_CYC      7'd64
`define WOSC_STOP_DLY_CYC    12'd4000
`define WOSC_STOP_FAST_CYC   12'd4
`define WOSC_WDOG_DIV_LOG2   15
`define WOSC_ROM_PAGE_EXP    4'h7
`define WOSC_ROM_PAGE_STD    4'hf
`define WOSC_RAM_LOW_LIMIT   8'h40

`endif

// ===== logic/wosc_pkg.sv
/*
 * Shared types of the configuration bank.
 * Assumes wosc_params.svh on the include path.
 */
`include "wosc_params.svh"

package wosc_pkg;

    // ------------------------------------------------------------------------
    // Option register fields as carried to the rest of the chip
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       interrupt_edge_select;
        logic       stop_wake_delay_enable;
        logic       clock_monitor_enable;
        logic [1:0] watchdog_rate_select;
    } wosc_opt_t;

    // ------------------------------------------------------------------------
    // Memory decoder hits
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic reg_hit;
        logic ram_hit;
        logic rom_hit;
    } wosc_hit_t;

    // ------------------------------------------------------------------------
    // Stop wake-up sequencer
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        WOSC_RUN,
        WOSC_WAKE
    } wosc_wake_t;

endpackage

// ===== test/wosc_monitor.sv
/* Port checker of the configuration bank; bound into wosc_top, sees its ports. */
`timescale 1ns/1ps
`default_nettype none
module wosc_monitor
    import wosc_pkg::*;
#(
    parameter int WDOG_DIV_LOG2 = 15
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [15:0] cpu_addr,
    input wire wosc_hit_t   cpu_hit,
    input wire logic        stop_exit_req,
    input wire logic        cpu_resume,
    input wire logic        watchdog_disable,
    input wire logic        rom_map_enable,
    input wire wosc_opt_t   options,
    input wire logic        special_mode_flag,
    input wire logic        watchdog_tick
);
    // The strap lands on the first edge, so the flag is judged from the third on.
    logic [1:0] age_reg;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            age_reg <= 2'b00;
        else
            age_reg <= {age_reg[0], 1'b1};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_read(a); pready && !pwrite && paddr == a; endsequence
    sequence s_rom_off; !rom_map_enable ##1 !rom_map_enable; endsequence
    chk_ready_next: assert property (s_setup |=> pready) else $error("no ready");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    chk_cfg_zero: assert property (s_read(12'hfc) |-> prdata[7:3] == 5'h0 && !prdata[0])
        else $error("startup spare bits set");
    chk_opt_zero: assert property (s_read(12'he4) |-> prdata[7:6] == 2'h0 && !prdata[2])
        else $error("option spare bits set");
    chk_hit_window: assert property (cpu_addr[11:8] != 4'h0 |=> !cpu_hit[2] && !cpu_hit[1])
        else $error("window hit outside page start");
    chk_hit_single: assert property ($onehot0(cpu_hit)) else $error("two hits");
    chk_rom_page: assert property (cpu_hit.rom_hit |-> $past(cpu_addr[15:12]) inside {4'h7, 4'hf})
        else $error("rom hit on wrong page");
    chk_rom_off: assert property (s_rom_off |-> !cpu_hit.rom_hit) else $error("rom hit while off");
    chk_flag_noset: assert property (age_reg[1] && !$past(special_mode_flag) |-> !special_mode_flag)
        else $error("special flag set by software");
    chk_wake_fast: assert property (stop_exit_req && !options[3] |-> ##[5:6] cpu_resume)
        else $error("fast wake late");
    chk_wake_slow: assert property (stop_exit_req && options[3] |=> !cpu_resume [*8])
        else $error("slow wake early");
    chk_tick_gap: assert property (watchdog_tick |=> !watchdog_tick [*7]) else $error("tick gap");
    chk_wdog_write: assert property ($changed(watchdog_disable)
        |-> $past(psel && penable && pwrite && paddr == 12'hfc)) else $error("stray change");
endmodule
bind wosc_top wosc_monitor #(.WDOG_DIV_LOG2(WDOG_DIV_LOG2)) i_wosc_monitor (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .cpu_addr, .cpu_hit, .stop_exit_req,
    .cpu_resume, .watchdog_disable, .rom_map_enable, .options, .special_mode_flag, .watchdog_tick);
`default_nettype wire

// ===== test/write_once_system_config_tb_top.sv
/* Bench for the configuration bank.
   Assumes wosc_monitor is bound into wosc_top. */
`timescale 1ns/1ps
`default_nettype none
module write_once_system_config_tb_top
    import wosc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stop_exit_req;
    logic        mode_a_pin, mode_b_pin, cpu_resume, watchdog_disable, rom_map_enable;
    logic        special_mode_flag, watchdog_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cpu_addr;
    logic [7:0]  d;
    wosc_hit_t   cpu_hit;
    wosc_opt_t   options;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0, k;
    // A short prescaler keeps watchdog ticks frequent enough to be seen.
    wosc_top #(.WDOG_DIV_LOG2(3)) i_wosc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .mode_a_pin, .mode_b_pin, .cpu_addr,
        .cpu_hit, .stop_exit_req, .cpu_resume, .watchdog_disable, .rom_map_enable, .options,
        .special_mode_flag, .watchdog_tick);
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // One APB transfer; the request is held until ready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rst(input logic mb, input logic ma);
        presetn <= 1'b0;
        mode_b_pin <= mb;
        mode_a_pin <= ma;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [31:0] hit_exp(input logic [15:0] a, input logic [7:0] m,
                                            input logic [3:0] rp, input logic en);
        logic r, q;
        r = a[15:12] == m[3:0] && a[11:6] == 6'h0;
        q = a[15:12] == m[7:4] && a[11:8] == 4'h0 && a[7:6] != 2'b00 && !r;
        return {29'h0, r, q, en && a[15:12] == rp && !r && !q};
    endfunction
    // Random addresses steered toward the mapped pages.
    task automatic dec(input logic [7:0] m, input logic [3:0] rp, input logic en);
        logic [15:0] a;
        repeat (30)
        begin
            a = 16'($urandom);
            a[15:12] = a[2:1] == 2'd0 ? m[3:0] : a[2:1] == 2'd1 ? m[7:4] : a[1] ? rp : a[15:12];
            if (a[0])
                a[11:8] = 4'h0;
            @(posedge pclk);
            cpu_addr <= a;
            @(posedge pclk);
            #1 chk({29'h0, cpu_hit}, hit_exp(a, m, rp, en));
        end
    endtask
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] v, input logic [31:0] exp);
        apb(1'b1, a, v);
        apb(1'b0, a, 8'h0);
        chk(rd, exp);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, stop_exit_req, mode_a_pin, mode_b_pin, paddr, pwdata,
            cpu_addr} = '0;
        void'($urandom(32'he3e3));
        rst(1'b1, 1'b0);
        apb(1'b0, 12'hfc, 8'h0);
        chk(rd, 32'h02);
        chk_bit(rom_map_enable, 1'b1);
        apb(1'b0, 12'he4, 8'h0);
        chk(rd, 32'h10);
        chk_bit(special_mode_flag, 1'b0);
        wr_rd(12'hfc, 8'hff, 32'h06);
        wr_rd(12'hfc, 8'h02, 32'h06);
        wr_rd(12'he4, 8'hff, 32'h3b);
        wr_rd(12'he4, 8'h00, 32'h33);
        dec(8'h00, 4'hf, 1'b1);
        wr_rd(12'hf4, 8'h5a, 32'h00);
        apb(1'b0, 12'h004, 8'h0);
        chk_bit(err, 1'b1);
        stop_exit_req <= 1'b1;
        @(posedge pclk);
        stop_exit_req <= 1'b0;
        rst(1'b1, 1'b1);
        wr_rd(12'hf4, 8'h21, 32'h21);
        wr_rd(12'hf4, 8'h00, 32'h21);
        dec(8'h21, 4'h7, 1'b1);
        rst(1'b0, 1'b0);
        chk_bit(special_mode_flag, 1'b1);
        repeat (70) @(posedge pclk);
        apb(1'b1, 12'hf4, 8'h34);
        wr_rd(12'hf4, 8'h12, 32'h12);
        wr_rd(12'hfc, 8'h00, 32'h00);
        dec(8'h12, 4'hf, 1'b0);
        d = 8'($urandom) & 8'hef;
        wr_rd(12'he4, d, {24'h0, d & 8'h2b});
        stop_exit_req <= 1'b1;
        @(posedge pclk);
        stop_exit_req <= 1'b0;
        for (k = 0; k < 10 && cpu_resume !== 1'b1; k++)
            @(posedge pclk);
        chk_bit(cpu_resume, 1'b1);
        apb(1'b1, 12'hf0, 8'h00);
        apb(1'b1, 12'hf0, 8'h40);
        chk_bit(special_mode_flag, 1'b0);
        wr_rd(12'hf4, 8'h77, 32'h12);
        tally_and_finish();
    end
endmodule
`default_nettype wire
